// ### src/bit_compare_bcd_ops.sv
// executor for carry and, compare-jump, clear, complement and decimal adjust
// Summary of operation
// - carry and with a bit clears carry on a zero source bit, else keeps it, no other flag.
// - the complemented-source form uses the inverted bit and leaves the bit itself alone.
// - opcode 82h plus bit address is carry and with true bit, two bytes, two cycles.
// - opcode b0h plus bit address is carry and with inverted bit, two bytes, two cycles.
// - compare-jump advances pc by three then adds the signed offset only when unequal.
// - compare-jump sets carry when first operand is below second, and modifies neither.
// - b5h compares acc with a direct byte, b4h with immediate, three bytes, two cycles.
// - 10111rrr compares a register and 1011011i an indirect byte with immediate data.
// - e4h zeroes the accumulator with no flag change, one byte.
// - c3h clears carry in one cycle, c2h plus bit address clears that bit.
// - f4h inverts every accumulator bit, flags unchanged, one byte.
// - b3h inverts carry in one cycle, b2h plus bit address inverts that bit.
// - a bit complement on a port pin reads the output latch, not the pin.
// - decimal adjust adds 6 when low nibble above 9 or half carry set, carry only set.
// - then adds 6 to the high nibble when carry set or high nibble above 9, carry only set.
// - half carry is set by add and add-with-carry on carry out of bit 3, else cleared.
module bit_compare_bcd_ops (
    input  wire logic        core_clk,      // 20 MHz core clock
    input  wire logic        rst_n,         // async reset, active low
    // instruction stream from program memory
    input  wire logic        instr_valid,   // opcode and operand bytes present
    output logic             instr_ready,   // block accepts instruction this cycle
    input  wire logic [7:0]  opcode,        // first instruction byte
    input  wire logic [7:0]  operand1,      // second byte: bit/direct address or data
    input  wire logic [7:0]  operand2,      // third byte: relative jump offset
    input  wire logic [15:0] pc_in,         // address of the opcode byte
    // operand read path from data and bit space
    input  wire logic [7:0]  mem_byte,      // direct, register or indirect byte
    input  wire logic        bit_value,     // addressed bit, pin value for ports
    input  wire logic        bit_is_port,   // addressed bit lies in a port
    input  wire logic        bit_latch,     // port output latch bit
    // add instruction side band for the half carry
    input  wire logic        add_done,      // an add or add-with-carry retired
    input  wire logic        add_half,      // carry out of bit 3 of that add
    // results
    output logic             done,          // one-cycle pulse, instruction retired
    output logic             unsupported,   // one-cycle pulse, opcode not handled
    output logic [15:0]      pc_out,        // next program counter
    output logic [7:0]       acc,           // accumulator
    output logic             carry_flag,    // carry flag
    output logic             half_carry_flag, // half carry flag
    output logic             bit_we,        // one-cycle pulse, write bit
    output logic [7:0]       bit_addr,      // bit address for write
    output logic             bit_wdata      // bit data for write
);
    ////////////////////////////////////////////////////////////////////////////

    typedef enum logic [1:0] {IDLE, EXEC, RETIRE} phase_t;

    typedef enum logic [3:0] {
        K_NONE, K_AND_BIT, K_AND_NBIT, K_CMP_ACC, K_CMP_IMM_OP,
        K_CLR_ACC, K_CLR_C, K_CLR_BIT, K_CPL_ACC, K_CPL_C, K_CPL_BIT, K_DA
    } kind_t;

    typedef struct packed {
        phase_t      phase;
        kind_t       kind;
        logic [1:0]  cyc_left;
        logic [15:0] pc;
        logic [7:0]  acc;
        logic        carry;
        logic        half;
        logic        done;
        logic        unsupported;
        logic        bit_we;
        logic [7:0]  bit_addr;
        logic        bit_wdata;
    } state_t;

    state_t cur;
    state_t next_cur;

    logic [7:0] da_acc;
    logic       da_carry;

    ////////////////////////////////////////////////////////////////////////////

    function automatic kind_t decode(input logic [7:0] op);
        kind_t k;
        k = K_NONE;
        if (op == bitop_pkg::OP_AND_BIT)                k = K_AND_BIT;
        else if (op == bitop_pkg::OP_AND_NBIT)          k = K_AND_NBIT;
        else if (op == bitop_pkg::OP_CMP_DIR)           k = K_CMP_ACC;
        else if (op == bitop_pkg::OP_CMP_IMM)           k = K_CMP_IMM_OP;
        else if (op[7:3] == bitop_pkg::OP_CMP_REG_HI)   k = K_CMP_IMM_OP;
        else if (op[7:1] == bitop_pkg::OP_CMP_IND_HI)   k = K_CMP_IMM_OP;
        else if (op == bitop_pkg::OP_CLR_ACC)           k = K_CLR_ACC;
        else if (op == bitop_pkg::OP_CLR_CARRY)         k = K_CLR_C;
        else if (op == bitop_pkg::OP_CLR_BIT)           k = K_CLR_BIT;
        else if (op == bitop_pkg::OP_CPL_ACC)           k = K_CPL_ACC;
        else if (op == bitop_pkg::OP_CPL_CARRY)         k = K_CPL_C;
        else if (op == bitop_pkg::OP_CPL_BIT)           k = K_CPL_BIT;
        else if (op == bitop_pkg::OP_DEC_ADJ)           k = K_DA;
        return k;
    endfunction

    // two-cycle instructions stretch by one idle machine cycle
    function automatic logic [1:0] cycles_of(input kind_t k);
        logic [1:0] c;
        c = bitop_pkg::CYC_ONE;
        if (k == K_AND_BIT || k == K_AND_NBIT || k == K_CMP_ACC || k == K_CMP_IMM_OP) begin
            c = bitop_pkg::CYC_TWO;
        end
        return c;
    endfunction

    function automatic logic [15:0] length_of(input kind_t k);
        logic [15:0] n;
        unique case (k)
            K_CMP_ACC, K_CMP_IMM_OP:             n = bitop_pkg::LEN_THREE;
            K_AND_BIT, K_AND_NBIT, K_CLR_BIT,
            K_CPL_BIT:                           n = bitop_pkg::LEN_TWO;
            default:                             n = bitop_pkg::LEN_ONE;
        endcase
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////

    decimal_adjust u_da (
        .acc_in    (cur.acc),
        .carry_in  (cur.carry),
        .half_in   (cur.half),
        .acc_out   (da_acc),
        .carry_out (da_carry)
    );

    assign instr_ready = (cur.phase == IDLE);

    always_comb begin
        logic [7:0]  cmp_a;
        logic [7:0]  cmp_b;
        logic        src_bit;
        logic [15:0] seq_pc;
        cmp_a   = 8'h00;
        cmp_b   = 8'h00;
        src_bit = 1'b0;
        seq_pc  = 16'h0000;

        next_cur             = cur;
        next_cur.done        = 1'b0;
        next_cur.unsupported = 1'b0;
        next_cur.bit_we      = 1'b0;

        // half carry tracks the last add; a decimal adjust never writes it
        if (add_done) begin
            next_cur.half = add_half;
        end

        unique case (cur.phase)
            IDLE: begin
                if (instr_valid) begin
                    next_cur.kind     = decode(opcode);
                    next_cur.cyc_left = cycles_of(decode(opcode));
                    next_cur.pc       = pc_in;
                    if (decode(opcode) == K_NONE) begin
                        next_cur.unsupported = 1'b1;
                    end else begin
                        next_cur.phase = EXEC;
                    end
                end
            end
            EXEC: begin
                // first cycle of a two-cycle instruction only waits
                if (cur.cyc_left == bitop_pkg::CYC_TWO) begin
                    next_cur.cyc_left = bitop_pkg::CYC_ONE;
                end else begin
                    next_cur.phase = RETIRE;
                    seq_pc = cur.pc + length_of(cur.kind);
                    next_cur.pc = seq_pc;
                    // complement takes port bits from the output latch, not the pin; carry and reads bit_value
                    src_bit = bit_is_port ? bit_latch : bit_value;
                    unique case (cur.kind)
                        K_AND_BIT: begin
                            if (!bit_value) next_cur.carry = 1'b0;
                        end
                        K_AND_NBIT: begin
                            // source bit not written back
                            if (bit_value) next_cur.carry = 1'b0;
                        end
                        K_CMP_ACC, K_CMP_IMM_OP: begin
                            // operands are only read, never written
                            cmp_a = (cur.kind == K_CMP_ACC || opcode == bitop_pkg::OP_CMP_IMM)
                                    ? cur.acc : mem_byte;
                            cmp_b = (cur.kind == K_CMP_ACC) ? mem_byte : operand1;
                            if (cur.kind == K_CMP_ACC) cmp_a = cur.acc;
                            next_cur.carry = (cmp_a < cmp_b);
                            if (cmp_a != cmp_b) begin
                                next_cur.pc = seq_pc + {{8{operand2[7]}}, operand2};
                            end
                        end
                        K_CLR_ACC: next_cur.acc   = bitop_pkg::ACC_RESET;
                        K_CLR_C:   next_cur.carry = 1'b0;
                        K_CLR_BIT: begin
                            next_cur.bit_we    = 1'b1;
                            next_cur.bit_addr  = operand1;
                            next_cur.bit_wdata = 1'b0;
                        end
                        K_CPL_ACC: next_cur.acc   = ~cur.acc;
                        K_CPL_C:   next_cur.carry = ~cur.carry;
                        K_CPL_BIT: begin
                            next_cur.bit_we    = 1'b1;
                            next_cur.bit_addr  = operand1;
                            next_cur.bit_wdata = ~src_bit;
                        end
                        K_DA: begin
                            next_cur.acc   = da_acc;
                            next_cur.carry = da_carry;
                        end
                        default: ;
                    endcase
                    next_cur.done = 1'b1;
                end
            end
            RETIRE: begin
                next_cur.phase = IDLE;
            end
            default: next_cur.phase = IDLE;
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cur <= '{phase: IDLE, kind: K_NONE, cyc_left: 2'h0,
                     pc: bitop_pkg::PC_RESET, acc: bitop_pkg::ACC_RESET,
                     carry: 1'b0, half: 1'b0, done: 1'b0, unsupported: 1'b0,
                     bit_we: 1'b0, bit_addr: 8'h00, bit_wdata: 1'b0};
        end else begin
            cur <= next_cur;
        end
    end

    assign done            = cur.done;
    assign unsupported     = cur.unsupported;
    assign pc_out          = cur.pc;
    assign acc             = cur.acc;
    assign carry_flag      = cur.carry;
    assign half_carry_flag = cur.half;
    assign bit_we          = cur.bit_we;
    assign bit_addr        = cur.bit_addr;
    assign bit_wdata       = cur.bit_wdata;
endmodule // bit_compare_bcd_ops

// ### src/bitop_pkg.sv
// shared constants for the bit, compare and decimal adjust executor
package bitop_pkg;
    // opcodes handled by this block
    localparam logic [7:0] OP_AND_BIT     = 8'h82;
    localparam logic [7:0] OP_AND_NBIT    = 8'hb0;
    localparam logic [7:0] OP_CMP_DIR     = 8'hb5;
    localparam logic [7:0] OP_CMP_IMM     = 8'hb4;
    localparam logic [4:0] OP_CMP_REG_HI  = 5'h17;   // 10111rrr
    localparam logic [6:0] OP_CMP_IND_HI  = 7'h5b;   // 1011011i
    localparam logic [7:0] OP_CLR_ACC     = 8'he4;
    localparam logic [7:0] OP_CLR_CARRY   = 8'hc3;
    localparam logic [7:0] OP_CLR_BIT     = 8'hc2;
    localparam logic [7:0] OP_CPL_ACC     = 8'hf4;
    localparam logic [7:0] OP_CPL_CARRY   = 8'hb3;
    localparam logic [7:0] OP_CPL_BIT     = 8'hb2;
    localparam logic [7:0] OP_DEC_ADJ     = 8'hd4;
    // instruction lengths and pc advance
    localparam logic [15:0] LEN_ONE       = 16'h0001;
    localparam logic [15:0] LEN_TWO       = 16'h0002;
    localparam logic [15:0] LEN_THREE     = 16'h0003;
    // machine cycle counts
    localparam logic [1:0]  CYC_ONE       = 2'h1;
    localparam logic [1:0]  CYC_TWO       = 2'h2;
    // decimal adjust constants
    localparam logic [3:0]  BCD_MAX_DIGIT = 4'h9;
    localparam logic [8:0]  BCD_LOW_FIX   = 9'h006;
    localparam logic [8:0]  BCD_HIGH_FIX  = 9'h060;
    // reset values
    localparam logic [7:0]  ACC_RESET     = 8'h00;
    localparam logic [15:0] PC_RESET      = 16'h0000;
endpackage

// ### src/decimal_adjust.sv
// combinational decimal adjust of the accumulator after a bcd add
module decimal_adjust (
    input  wire logic [7:0] acc_in,      // accumulator before adjust
    input  wire logic       carry_in,    // carry before adjust
    input  wire logic       half_in,     // half carry flag
    output logic      [7:0] acc_out,     // adjusted accumulator
    output logic            carry_out    // carry after adjust, never cleared
);
    logic [8:0] low_sum;
    logic [8:0] high_sum;
    logic       mid_carry;

    always_comb begin
        low_sum = {1'b0, acc_in};
        if (acc_in[3:0] > bitop_pkg::BCD_MAX_DIGIT || half_in) begin
            low_sum = {1'b0, acc_in} + bitop_pkg::BCD_LOW_FIX;
        end
        // carry only ever set here, never cleared
        mid_carry = carry_in | low_sum[8];
        high_sum  = {1'b0, low_sum[7:0]};
        if (mid_carry || low_sum[7:4] > bitop_pkg::BCD_MAX_DIGIT) begin
            high_sum = {1'b0, low_sum[7:0]} + bitop_pkg::BCD_HIGH_FIX;
        end
        acc_out   = high_sum[7:0];
        carry_out = mid_carry | high_sum[8];
    end
endmodule // decimal_adjust

// ### tb/data_space_model.sv
// behavioural data and bit space seen by the executor
module data_space_model (
    input  wire logic       core_clk,    // core clock
    input  wire logic [7:0] addr,        // operand byte used as address
    input  wire logic       bit_we,      // bit write strobe
    input  wire logic [7:0] bit_addr,    // bit write address
    input  wire logic       bit_wdata,   // bit write data
    output logic      [7:0] mem_byte,    // addressed byte
    output logic            bit_value,   // addressed bit
    output logic            bit_is_port, // upper half is port pins
    output logic            bit_latch    // port output latch
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [255:0] bits = {128{2'b10}};
    assign mem_byte    = addr ^ 8'h3c;
    assign bit_is_port = addr[7];
    assign bit_latch   = bits[addr];
    // pins read opposite to the latch, so a latch/pin mix-up shows
    assign bit_value   = addr[7] ? ~bits[addr] : bits[addr];
    always @(posedge core_clk) if (bit_we) bits[bit_addr] <= bit_wdata;
endmodule // data_space_model

// ### tb/bit_compare_bcd_ops_sva.sv
// assertions on the executor ports
module bit_compare_bcd_ops_sva (
    input wire logic       core_clk,        // clock
    input wire logic       rst_n,           // reset
    input wire logic       instr_valid,     // request
    input wire logic       instr_ready,     // accept
    input wire logic [7:0] opcode,          // opcode
    input wire logic [7:0] operand1,        // second byte
    input wire logic       bit_value,       // source bit
    input wire logic       add_done,        // add retired
    input wire logic       add_half,        // add nibble carry
    input wire logic       done,            // retired
    input wire logic       unsupported,     // not ours
    input wire logic [7:0] acc,             // accumulator
    input wire logic       carry_flag,      // carry
    input wire logic       half_carry_flag, // half carry
    input wire logic       bit_we,          // bit write
    input wire logic [7:0] bit_addr,        // bit address
    input wire logic       bit_wdata        // bit data
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    wire take = instr_valid && instr_ready;
    property p_and; take && opcode == 8'h82 |-> ##3 done
        && carry_flag == ($past(carry_flag, 3) && $past(bit_value)); endproperty
    a_and: assert property (p_and) else $error("carry and wrong");
    property p_cmp; take && opcode == 8'hb4 |-> ##3 done
        && carry_flag == ($past(acc, 3) < $past(operand1, 3)); endproperty
    a_cmp: assert property (p_cmp) else $error("compare carry wrong");
    property p_clr_carry; take && opcode == 8'hc3 |-> ##2 done && !carry_flag; endproperty
    a_clr_carry: assert property (p_clr_carry) else $error("carry not cleared");
    property p_clr_bit; take && opcode == 8'hc2 |-> ##2 bit_we && !bit_wdata
        && bit_addr == $past(operand1, 2); endproperty
    a_clr_bit: assert property (p_clr_bit) else $error("bit clear wrong");
    property p_cpl_acc; take && opcode == 8'hf4 |-> ##2 acc == ~$past(acc, 2); endproperty
    a_cpl_acc: assert property (p_cpl_acc) else $error("acc complement wrong");
    property p_cpl_c; take && opcode == 8'hb3 |-> ##2 carry_flag != $past(carry_flag, 2);
    endproperty
    a_cpl_c: assert property (p_cpl_c) else $error("carry complement wrong");
    property p_half; add_done |=> half_carry_flag == $past(add_half); endproperty
    a_half: assert property (p_half) else $error("half carry not taken");
    property p_busy; done |-> !instr_ready ##1 !done; endproperty
    a_busy: assert property (p_busy) else $error("retire phase wrong");
    property p_unsup; take && opcode == 8'h00 |=> unsupported && !done; endproperty
    a_unsup: assert property (p_unsup) else $error("foreign opcode kept");
endmodule // bit_compare_bcd_ops_sva
bind bit_compare_bcd_ops bit_compare_bcd_ops_sva bit_compare_bcd_ops_sva_i (.core_clk, .rst_n,
    .instr_valid, .instr_ready, .opcode, .operand1, .bit_value, .add_done, .add_half, .done,
    .unsupported, .acc, .carry_flag, .half_carry_flag, .bit_we, .bit_addr, .bit_wdata);

// ### tb/test_bit_compare_bcd_ops.sv
// self-checking bench for the bit, compare and decimal adjust executor
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH t=%0t got %h exp %h", $time, g, e); end end
module test_bit_compare_bcd_ops;
    timeunit 1ns;
    timeprecision 1ns;
    logic        core_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0;
    logic        add_done = 1'b0, add_half = 1'b0;
    logic [7:0]  opcode = 8'h00, operand1 = 8'h00, operand2 = 8'h00;
    logic [15:0] pc_in = 16'h0100;
    logic        instr_ready, done, unsupported, carry_flag, half_carry_flag;
    logic        bit_we, bit_wdata, bit_value, bit_is_port, bit_latch;
    logic [7:0]  acc, bit_addr, mem_byte;
    logic [15:0] pc_out;
    int          miscompares = 0, tests_run = 0;
    always #25 core_clk = ~core_clk;
    bit_compare_bcd_ops bit_compare_bcd_ops_i (.core_clk, .rst_n, .instr_valid, .instr_ready,
        .opcode, .operand1, .operand2, .pc_in, .mem_byte, .bit_value, .bit_is_port, .bit_latch,
        .add_done, .add_half, .done, .unsupported, .pc_out, .acc, .carry_flag,
        .half_carry_flag, .bit_we, .bit_addr, .bit_wdata);
    data_space_model data_space_model_i (.core_clk, .addr(operand1), .bit_we, .bit_addr,
        .bit_wdata, .mem_byte, .bit_value, .bit_is_port, .bit_latch);
    ////////////////////////////////////////////////////////////////////////////////
    task automatic stop_test();
        $display("compares %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // operands stay put until the next instruction, as the executor requires
    task automatic run(input logic [7:0] op, input logic [7:0] o1, input logic [7:0] o2);
        int n;
        @(posedge core_clk);
        opcode <= op;
        operand1 <= o1;
        operand2 <= o2;
        instr_valid <= 1'b1;
        @(posedge core_clk);
        instr_valid <= 1'b0;
        for (n = 0; n < 8; n++) begin
            @(negedge core_clk);
            if (done === 1'b1 || unsupported === 1'b1) break;
        end
        if (n == 8) begin
            miscompares++;
            stop_test();
        end
    endtask
    task automatic t_acc_carry();
        run(8'hc3, 8'h00, 8'h00);
        `CHK(carry_flag, 1'b0)
        run(8'hb3, 8'h00, 8'h00);
        `CHK(carry_flag, 1'b1)
        run(8'he4, 8'h00, 8'h00);
        `CHK({acc, carry_flag, pc_out}, {8'h00, 1'b1, 16'h0101})
        run(8'hf4, 8'h00, 8'h00);
        `CHK({acc, carry_flag, pc_out}, {8'hff, 1'b1, 16'h0101})
        run(8'hb3, 8'h00, 8'h00);
        `CHK({carry_flag, pc_out}, {1'b0, 16'h0101})
        $display("acc and carry test done");
    endtask
    task automatic t_and();
        run(8'hb3, 8'h00, 8'h00);
        run(8'h82, 8'h03, 8'h00);
        `CHK({carry_flag, pc_out}, {1'b1, 16'h0102})
        run(8'h82, 8'h02, 8'h00);
        `CHK(carry_flag, 1'b0)
        run(8'hb3, 8'h00, 8'h00);
        run(8'hb0, 8'h02, 8'h00);
        `CHK({carry_flag, pc_out}, {1'b1, 16'h0102})
        run(8'hb0, 8'h03, 8'h00);
        `CHK({carry_flag, data_space_model_i.bits[3]}, 2'b01)
        $display("carry and test done");
    endtask
    task automatic t_bits();
        run(8'hc2, 8'h07, 8'h00);
        `CHK({bit_we, bit_addr, bit_wdata, pc_out}, {1'b1, 8'h07, 1'b0, 16'h0102})
        run(8'hb2, 8'h02, 8'h00);
        `CHK({bit_we, bit_addr, bit_wdata}, {1'b1, 8'h02, 1'b1})
        run(8'hb2, 8'h85, 8'h00);
        `CHK({bit_we, bit_wdata}, 2'b10)
        $display("bit write test done");
    endtask
    task automatic t_cmp();
        logic [7:0] op;
        run(8'he4, 8'h00, 8'h00);
        // b5 compares acc with the byte, the rest compare the byte with immediate
        for (int k = 0; k < 11; k++) begin
            op = 8'hb5 + 8'(k);
            run(op, 8'h40, 8'h10);
            `CHK({carry_flag, pc_out, acc}, {op == 8'hb5, 16'h0113, 8'h00})
        end
        run(8'hb4, 8'h00, 8'hfe);
        `CHK({carry_flag, pc_out}, {1'b0, 16'h0103})
        run(8'hb4, 8'h10, 8'hfe);
        `CHK({carry_flag, pc_out}, {1'b1, 16'h0101})
        $display("compare test done");
    endtask
    task automatic adj(input logic [7:0] a, input logic h, input logic [8:0] exp);
        run(8'he4, 8'h00, 8'h00);
        if (a == 8'hff) run(8'hf4, 8'h00, 8'h00);
        run(8'hc3, 8'h00, 8'h00);
        @(posedge core_clk);
        add_done <= 1'b1;
        add_half <= h;
        @(posedge core_clk);
        add_done <= 1'b0;
        @(negedge core_clk);
        `CHK(half_carry_flag, h)
        run(8'hd4, 8'h00, 8'h00);
        `CHK({carry_flag, acc, pc_out}, {exp, 16'h0101})
    endtask
    task automatic t_da();
        adj(8'hff, 1'b0, 9'h165);
        adj(8'h00, 1'b1, 9'h006);
        $display("decimal adjust test done");
    endtask
    task automatic t_unsup();
        run(8'h00, 8'h00, 8'h00);
        `CHK({unsupported, done}, 2'b10)
        $display("foreign opcode test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge core_clk);
        rst_n <= 1'b1;
        @(negedge core_clk);
        `CHK({acc, carry_flag, instr_ready, pc_out}, {8'h00, 1'b0, 1'b1, 16'h0000})
        t_acc_carry();
        t_and();
        t_bits();
        t_cmp();
        t_da();
        t_unsup();
        stop_test();
    end
endmodule // test_bit_compare_bcd_ops
